// *** testbench/dmc_asserts.sv ***
// Purpose: link protocol checks between the engine and the host
// Assumes: single clock, nrst asynchronous active low
// Notes:   watches the link wires only; instantiated beside the link
`timescale 1ns/1ps
module dmc_asserts (
  // clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // bus borrow
  input wire logic        bus_req,
  input wire logic        bus_ack,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  mem_rdata,
  // converter
  input wire logic [3:0]  adc_input,
  input wire logic        adc_start,
  input wire logic [2:0]  irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  chk_ack_after_req: assert property (bus_ack |-> $past(bus_req))
    else $error("bus_ack without a request one cycle before");
  chk_mem_granted: assert property ((mem_rd || mem_wr) |-> bus_req && bus_ack)
    else $error("memory access outside a bus grant");
  chk_req_drop: assert property ($fell(bus_req) |-> $past(mem_wr))
    else $error("bus released without a final write");
  chk_req_gap: assert property ($fell(bus_req) |=> !bus_req)
    else $error("new request before the grant fell");
  chk_rd_to_wr: assert property (mem_rd |-> ##2 mem_wr)
    else $error("read not followed by its write");
  chk_copy_data: assert property (mem_rd ##2 mem_wr |-> mem_wdata == $past(mem_rdata))
    else $error("written byte differs from the byte read");
  // second byte of a word comes from the next address
  chk_word_next: assert property (mem_wr ##1 mem_rd |->
      mem_addr == $past(mem_addr, 3) + 12'h001)
    else $error("second word byte not at next address");
  chk_pair_addr: assert property (mem_wr && $past(mem_wr) |->
      mem_addr[0] && mem_addr == $past(mem_addr) + 12'h001)
    else $error("result pair not even then odd");
  chk_pair_msb: assert property (mem_wr && $past(mem_wr) |-> $past(mem_wdata) <= 8'h03)
    else $error("result upper byte wider than two bits");
  chk_input_step: assert property ($changed(adc_input) |->
      adc_input == 4'h0 || adc_input == $past(adc_input) + 4'h1)
    else $error("converter input skipped");
  chk_wrap_restart: assert property (irq[2] |-> adc_start && adc_input == 4'h0)
    else $error("converter interrupt without restart on input zero");
endmodule : dmc_asserts

// *** testbench/tb.sv ***
// Purpose: self-checking bench, engine and host joined by the link
// Assumes: grant enabled through host control before any trigger
// Notes:   all traffic enters through the host APB port
`timescale 1ns/1ps
module tb;
  import dmc_pkg::*;
  typedef struct packed {
    logic       ch;
    logic [7:0] ctl;
    logic [9:0] trig;
    logic       mv;
  } dmc_row_t;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic [2:0]  irq_flags;
  logic        busy;
  logic [31:0] rd;
  int          errors = 0;
  int          compares = 0;
  int          cyc = 0;
  dmc_row_t    rows [16];

  always #10 clock = ~clock;

  dmc_if i_dmc_if ();
  dmc_engine i_dmc_engine (.clock(clock), .nrst(nrst), .lnk(i_dmc_if.dev),
    .irq_flags(irq_flags), .busy(busy));
  dmc_host i_dmc_host (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .lnk(i_dmc_if.host));
  dmc_asserts i_dmc_asserts (.clock(clock), .nrst(nrst), .bus_req(i_dmc_if.bus_req),
    .bus_ack(i_dmc_if.bus_ack), .mem_addr(i_dmc_if.mem_addr), .mem_rd(i_dmc_if.mem_rd),
    .mem_wr(i_dmc_if.mem_wr), .mem_wdata(i_dmc_if.mem_wdata),
    .mem_rdata(i_dmc_if.mem_rdata), .adc_input(i_dmc_if.adc_input),
    .adc_start(i_dmc_if.adc_start), .irq(i_dmc_if.irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic ewr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, DMC_A_REGCMD, {11'h000, 1'b1, d, a});
  endtask : ewr

  task automatic ec(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b1, DMC_A_REGCMD, {11'h000, 1'b0, 8'h00, a});
    repeat (2) @(posedge clock);
    apb(1'b0, DMC_A_REGSTAT, 32'h0);
    chk(nm, e, rd[7:0]);
  endtask : ec

  task automatic mwr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, DMC_A_MEMCMD, {11'h000, 1'b1, d, a});
  endtask : mwr

  task automatic mc(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b1, DMC_A_MEMCMD, {11'h000, 1'b0, 8'h00, a});
    apb(1'b0, DMC_A_MEMDATA, 32'h0);
    chk(nm, e, rd[7:0]);
  endtask : mc

  // event pulse, then wait for the borrow to start and end
  task automatic fire(input logic [31:0] ev);
    int n;
    apb(1'b1, DMC_A_EVENT, ev);
    n = 0;
    while (busy !== 1'b1 && n < 8) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(posedge clock);
      n++;
    end
    repeat (2) @(posedge clock);
  endtask : fire

  // hang guard, run needs under two thousand cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      report_and_stop;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    dmc_row_t   r;
    logic [11:0] o;
    logic [7:0]  d;
    rows = '{'{1'b0, 8'hA0, 10'h001, 1'b1}, '{1'b0, 8'hA1, 10'h002, 1'b1},
             '{1'b0, 8'hA2, 10'h004, 1'b1}, '{1'b0, 8'hA3, 10'h008, 1'b1},
             '{1'b0, 8'hA4, 10'h010, 1'b1}, '{1'b0, 8'hA5, 10'h020, 1'b1},
             '{1'b0, 8'hA6, 10'h100, 1'b1}, '{1'b1, 8'hA4, 10'h040, 1'b1},
             '{1'b1, 8'hA5, 10'h080, 1'b1}, '{1'b1, 8'hA6, 10'h200, 1'b1},
             '{1'b1, 8'hA0, 10'h001, 1'b1}, '{1'b0, 8'hA7, 10'h3FF, 1'b0},
             '{1'b0, 8'h20, 10'h001, 1'b0}, '{1'b0, 8'hA0, 10'h002, 1'b0},
             '{1'b0, 8'h80, 10'h001, 1'b1}, '{1'b1, 8'hA4, 10'h010, 1'b0}};
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    apb(1'b1, DMC_A_CTRL, 32'h1);
    ec("ctl0 reset", DMC_CTL0, DMC_CTL_RST);
    ec("ctl1 reset", DMC_CTL1, DMC_CTL_RST);
    // byte transfers, every trigger code, refused triggers
    for (int i = 0; i < 16; i++) begin
      r = rows[i];
      o = r.ch ? 12'h008 : 12'h000;
      d = 8'hA0 + 8'(i);
      mwr(12'hF40, d);
      mwr(12'h110 + 12'(i), 8'h55);
      ewr(DMC_IO0 + o, 8'h40);
      ewr(DMC_HN0 + o, 8'h31);
      ewr(DMC_START0 + o, 8'h10 + 8'(i));
      ewr(DMC_END0 + o, 8'hFF);
      ewr(DMC_CTL0 + o, r.ctl);
      fire({22'h0, r.trig});
      mc("dest", 12'h110 + 12'(i), (r.mv && r.ctl[5]) ? d : 8'h55);
      mc("periph", 12'hF40, (r.mv && !r.ctl[5]) ? 8'h55 : d);
      ec("current", DMC_START0 + o, 8'h10 + 8'(i) + {7'h00, r.mv});
      ewr(DMC_CTL0 + o, 8'h00);
    end
    // word at the end address, single pass, interrupt enabled
    mwr(12'hF50, 8'h11);
    mwr(12'hF51, 8'h22);
    ewr(DMC_IO0, 8'h50);
    ewr(DMC_HN0, 8'h11);
    ewr(DMC_START0, 8'h20);
    ewr(DMC_END0, 8'h20);
    ewr(DMC_CTL0, 8'hB8);
    fire(32'h1);
    mc("word even", 12'h120, 8'h11);
    mc("word odd", 12'h121, 8'h22);
    ec("reload", DMC_START0, 8'h20);
    ec("single pass", DMC_CTL0, 8'h38);
    chk("chan0_irq_indicator", 32'h1, irq_flags[0]);
    ec("status", DMC_ASTAT, 8'h01);
    ec("status cleared", DMC_ASTAT, 8'h00);
    // loop mode keeps running, no interrupt
    ewr(DMC_IO1, 8'h40);
    ewr(DMC_HN1, 8'h11);
    ewr(DMC_START1, 8'h30);
    ewr(DMC_END1, 8'h31);
    ewr(DMC_CTL1, 8'hE0);
    fire(32'h1);
    fire(32'h1);
    ec("loop reload", DMC_START1, 8'h30);
    ec("loop on", DMC_CTL1, 8'hE0);
    chk("chan1_irq_indicator", 32'h0, irq_flags[1]);
    ewr(DMC_CTL1, 8'h00);
    // converter over inputs 0 and 1
    ewr(DMC_ABASE, 8'h72);
    ewr(DMC_ACTL, 8'hC1);
    fire(32'h02AB0400);
    mc("adc msb", 12'h720, 8'h02);
    mc("adc lsb", 12'h721, 8'hAB);
    apb(1'b0, DMC_A_STATUS, 32'h0);
    chk("next input", 32'h1, rd[8:5]);
    fire(32'h01550400);
    mc("adc msb 1", 12'h722, 8'h01);
    mc("adc lsb 1", 12'h723, 8'h55);
    apb(1'b0, DMC_A_STATUS, 32'h0);
    chk("wrap input", 32'h0, rd[8:5]);
    chk("irq conv", 32'h1, irq_flags[2]);
    fire(32'h02AB0400);
    ewr(DMC_ACTL, 8'h00);
    apb(1'b0, DMC_A_STATUS, 32'h0);
    chk("disable input", 32'h0, rd[8:5]);
    report_and_stop;
  end
endmodule : tb

// *** verilog/dmc_engine.sv ***
`timescale 1ns/1ps
// Purpose: three-channel transfer engine, device end
// Assumes: bus_ack stays high while bus_req is high once granted
// Notes:   irq outputs are one-cycle pulses; indicators sit in status
module dmc_engine (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // link
  dmc_if.dev        lnk,
  // user side
  output logic [2:0] irq_flags,
  output logic       busy
);
  import dmc_pkg::*;

  typedef struct packed {
    logic [1:0][7:0]  ctl;
    logic [1:0][7:0]  io;
    logic [1:0][7:0]  hn;
    logic [1:0][7:0]  st_lo;
    logic [1:0][7:0]  end_lo;
    logic [1:0][11:0] cur;
    logic [7:0]       abase;
    logic [7:0]       actl;
    logic [3:0]       ain;
    logic [9:0]       adata;
    logic [2:0]       pend;
    logic [2:0]       irqf;
    logic [2:0]       irq;
    dmc_state_t       st;
    logic [1:0]       ch;
    logic             beat;
    logic             bus_req;
    logic [11:0]      mem_addr;
    logic             mem_rd;
    logic             mem_wr;
    logic [7:0]       mem_wdata;
    logic [7:0]       reg_rdata;
    logic             adc_start;
  } dmc_dev_t;

  dmc_dev_t s_ff;
  dmc_dev_t nxt_s;

  function automatic logic trig_hit(input logic ch, input logic [2:0] code,
                                    input logic [9:0] t);
    case (code)
      3'h0, 3'h1, 3'h2, 3'h3: trig_hit = t[code[1:0]];
      DMC_TS_UART0: trig_hit = ch ? t[6] : t[4];
      DMC_TS_UART1: trig_hit = ch ? t[7] : t[5];
      DMC_TS_TWI:   trig_hit = ch ? t[9] : t[8];
      default:      trig_hit = 1'b0;
    endcase
  endfunction : trig_hit

  // address of one side of a general transfer
  function automatic logic [11:0] side_addr(input dmc_dev_t s, input logic periph);
    logic g;
    g = s.ch[0];
    if (periph)
      side_addr = {DMC_PERIPH_NIB, s.io[g]} + {11'h000, s.beat};
    else
      side_addr = s.cur[g] + {11'h000, s.beat};
  endfunction : side_addr

  function automatic logic [11:0] adc_addr(input dmc_dev_t s);
    adc_addr = {s.abase[7:1], s.ain, s.beat};
  endfunction : adc_addr

  logic g;
  logic last_beat;

  always_comb begin
    nxt_s = s_ff;
    g = s_ff.ch[0];
    nxt_s.irq = 3'b000;
    nxt_s.adc_start = 1'b0;
    nxt_s.mem_rd = 1'b0;
    nxt_s.mem_wr = 1'b0;
    //////////////////////////////////////////////////////////////////////////
    // register access
    if (lnk.reg_wr) begin
      case (lnk.reg_addr)
        DMC_CTL0:   nxt_s.ctl[0] = lnk.reg_wdata;
        DMC_CTL1:   nxt_s.ctl[1] = lnk.reg_wdata;
        DMC_IO0:    nxt_s.io[0] = lnk.reg_wdata;
        DMC_IO1:    nxt_s.io[1] = lnk.reg_wdata;
        // one register holds both high nibbles: 3:0 for start, 7:4 for end
        DMC_HN0: begin
          nxt_s.hn[0] = lnk.reg_wdata;
          nxt_s.cur[0][11:8] = lnk.reg_wdata[3:0];
        end
        DMC_HN1: begin
          nxt_s.hn[1] = lnk.reg_wdata;
          nxt_s.cur[1][11:8] = lnk.reg_wdata[3:0];
        end
        DMC_START0: begin
          nxt_s.st_lo[0] = lnk.reg_wdata;
          nxt_s.cur[0][7:0] = lnk.reg_wdata;
        end
        DMC_START1: begin
          nxt_s.st_lo[1] = lnk.reg_wdata;
          nxt_s.cur[1][7:0] = lnk.reg_wdata;
        end
        DMC_END0:   nxt_s.end_lo[0] = lnk.reg_wdata;
        DMC_END1:   nxt_s.end_lo[1] = lnk.reg_wdata;
        DMC_ABASE:  nxt_s.abase = lnk.reg_wdata;
        DMC_ACTL: begin
          nxt_s.actl = lnk.reg_wdata & DMC_ACTL_MASK;
          if (!lnk.reg_wdata[DMC_B_EN])
            nxt_s.ain = 4'h0;
          else if (!s_ff.actl[DMC_B_EN]) begin
            nxt_s.ain = 4'h0;
            nxt_s.adc_start = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (lnk.reg_rd) begin
      case (lnk.reg_addr)
        DMC_CTL0:   nxt_s.reg_rdata = s_ff.ctl[0];
        DMC_CTL1:   nxt_s.reg_rdata = s_ff.ctl[1];
        DMC_IO0:    nxt_s.reg_rdata = s_ff.io[0];
        DMC_IO1:    nxt_s.reg_rdata = s_ff.io[1];
        DMC_HN0:    nxt_s.reg_rdata = s_ff.hn[0];
        DMC_HN1:    nxt_s.reg_rdata = s_ff.hn[1];
        DMC_START0: nxt_s.reg_rdata = s_ff.cur[0][7:0];
        DMC_START1: nxt_s.reg_rdata = s_ff.cur[1][7:0];
        DMC_END0:   nxt_s.reg_rdata = s_ff.end_lo[0];
        DMC_END1:   nxt_s.reg_rdata = s_ff.end_lo[1];
        DMC_ABASE:  nxt_s.reg_rdata = s_ff.abase;
        DMC_ACTL:   nxt_s.reg_rdata = s_ff.actl;
        DMC_ASTAT: begin
          nxt_s.reg_rdata = {s_ff.ain, 1'b0, s_ff.irqf};
          nxt_s.irqf = 3'b000;
        end
        default:    nxt_s.reg_rdata = 8'h00;
      endcase
    end
    //////////////////////////////////////////////////////////////////////////
    // transfer sequencer
    // word mode two beats
    last_beat = s_ff.beat || (!s_ff.ch[1] && !s_ff.ctl[g][DMC_B_WORD_SELECT_BIT]);
    case (s_ff.st)
      DMC_S_IDLE: begin
        nxt_s.beat = 1'b0;
        if (s_ff.pend[0])
          nxt_s.ch = 2'd0;
        else if (s_ff.pend[1])
          nxt_s.ch = 2'd1;
        else
          nxt_s.ch = 2'd2;
        if (|s_ff.pend) begin
          nxt_s.bus_req = 1'b1;
          nxt_s.st = DMC_S_REQ;
        end
      end
      DMC_S_REQ: begin
        if (lnk.bus_ack) begin
          if (s_ff.ch[1]) begin
            nxt_s.mem_addr = adc_addr(s_ff);
            nxt_s.mem_wdata = {6'h00, s_ff.adata[9:8]};
            nxt_s.mem_wr = 1'b1;
            nxt_s.st = DMC_S_WDONE;
          end else begin
            nxt_s.mem_addr = side_addr(s_ff, s_ff.ctl[g][DMC_B_DIR]);
            nxt_s.mem_rd = 1'b1;
            nxt_s.st = DMC_S_RWAIT;
          end
        end
      end
      DMC_S_RWAIT: nxt_s.st = DMC_S_RCAP;
      DMC_S_RCAP: begin
        nxt_s.mem_addr = side_addr(s_ff, !s_ff.ctl[g][DMC_B_DIR]);
        nxt_s.mem_wdata = lnk.mem_rdata;
        nxt_s.mem_wr = 1'b1;
        nxt_s.st = DMC_S_WDONE;
      end
      DMC_S_WDONE: begin
        if (!last_beat) begin
          nxt_s.beat = 1'b1;
          if (s_ff.ch[1]) begin
            nxt_s.mem_addr = {s_ff.abase[7:1], s_ff.ain, 1'b1};
            nxt_s.mem_wdata = s_ff.adata[7:0];
            nxt_s.mem_wr = 1'b1;
            nxt_s.st = DMC_S_WDONE;
          end else begin
            nxt_s.mem_addr = side_addr(s_ff, s_ff.ctl[g][DMC_B_DIR]) | 12'h001;
            nxt_s.mem_rd = 1'b1;
            nxt_s.st = DMC_S_RWAIT;
          end
        end else begin
          nxt_s.bus_req = 1'b0;
          nxt_s.pend[s_ff.ch] = 1'b0;
          nxt_s.st = DMC_S_REL;
          if (s_ff.ch[1]) begin
            if (s_ff.ain == s_ff.actl[3:0]) begin
              nxt_s.ain = 4'h0;
              if (s_ff.actl[DMC_B_LOOP]) begin
                nxt_s.irq[2] = 1'b1;
                nxt_s.irqf[2] = 1'b1;
              end
            end else begin
              nxt_s.ain = s_ff.ain + 4'h1;
            end
            nxt_s.adc_start = 1'b1;
          end else if (s_ff.cur[g] == {s_ff.hn[g][7:4], s_ff.end_lo[g]}) begin
            nxt_s.cur[g] = {s_ff.hn[g][3:0], s_ff.st_lo[g]};
            if (s_ff.ctl[g][DMC_B_IE]) begin
              nxt_s.irq[g] = 1'b1;
              nxt_s.irqf[g] = 1'b1;
            end
            if (!s_ff.ctl[g][DMC_B_LOOP])
              nxt_s.ctl[g][DMC_B_EN] = 1'b0;
          end else begin
            nxt_s.cur[g] = s_ff.cur[g] + (s_ff.ctl[g][DMC_B_WORD_SELECT_BIT] ? 12'h002 : 12'h001);
          end
        end
      end
      // wait for the grant to drop so a stale ack is never taken
      DMC_S_REL: begin
        if (!lnk.bus_ack)
          nxt_s.st = DMC_S_IDLE;
      end
      default: nxt_s.st = DMC_S_IDLE;
    endcase
    //////////////////////////////////////////////////////////////////////////
    // trigger capture; last so a set beats the same-cycle clear
    for (int i = 0; i < 2; i++) begin
      if (s_ff.ctl[i][DMC_B_EN] && trig_hit(i[0], s_ff.ctl[i][2:0], lnk.trig))
        nxt_s.pend[i] = 1'b1;
    end
    if (lnk.adc_done && s_ff.actl[DMC_B_EN] && !(s_ff.ch[1] && s_ff.st != DMC_S_IDLE)) begin
      nxt_s.adata = lnk.adc_data;
      nxt_s.pend[2] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
      s_ff.st <= DMC_S_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lnk.reg_rdata = s_ff.reg_rdata;
  assign lnk.bus_req   = s_ff.bus_req;
  assign lnk.mem_addr  = s_ff.mem_addr;
  assign lnk.mem_rd    = s_ff.mem_rd;
  assign lnk.mem_wr    = s_ff.mem_wr;
  assign lnk.mem_wdata = s_ff.mem_wdata;
  assign lnk.adc_start = s_ff.adc_start;
  assign lnk.adc_input = s_ff.ain;
  assign lnk.irq       = s_ff.irq;
  assign irq_flags     = s_ff.irqf;
  assign busy          = s_ff.bus_req;
endmodule : dmc_engine

// *** verilog/dmc_host.sv ***
`timescale 1ns/1ps
// Purpose: cpu side: bus grant, register file, triggers, APB command port
// Assumes: engine answers register reads one cycle after the strobe
// Notes:   APB memory commands stall while the engine owns the bus
module dmc_host #(
  parameter int AW = 12
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  // link
  dmc_if.host              lnk
);
  import dmc_pkg::*;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        grant_en;
    logic        bus_ack;
    logic        reg_wr;
    logic        reg_rd;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic [1:0]  rstage;
    logic [7:0]  rcap;
    logic [7:0]  mem_rdata;
    logic [11:0] maddr;
    logic [9:0]  trig;
    logic        adc_done;
    logic [9:0]  adc_data;
  } dmc_host_t;

  dmc_host_t s_ff;
  dmc_host_t nxt_s;
  logic [7:0] mem [2**AW];
  logic       access;
  logic       cpu_we;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.reg_wr = 1'b0;
    nxt_s.reg_rd = 1'b0;
    nxt_s.trig = 10'h000;
    nxt_s.adc_done = 1'b0;
    cpu_we = 1'b0;
    access = psel && penable;
    nxt_s.bus_ack = lnk.bus_req && s_ff.grant_en;
    if (lnk.mem_rd)
      nxt_s.mem_rdata = mem[lnk.mem_addr[AW-1:0]];
    nxt_s.rstage = {s_ff.rstage[0], 1'b0};
    if (s_ff.rstage[1])
      nxt_s.rcap = lnk.reg_rdata;
    if (access && !s_ff.pready) begin
      // cpu memory commands stall while the engine holds the bus; MEMDATA reads still go through
      if (!(paddr == DMC_A_MEMCMD && s_ff.bus_ack)) begin
        nxt_s.pready = 1'b1;
        case (paddr)
          DMC_A_CTRL:    nxt_s.prdata = {31'h0, s_ff.grant_en};
          DMC_A_REGSTAT: nxt_s.prdata = {23'h0, |s_ff.rstage, s_ff.rcap};
          DMC_A_MEMDATA: nxt_s.prdata = {24'h0, mem[s_ff.maddr[AW-1:0]]};
          DMC_A_STATUS:  nxt_s.prdata = {22'h0, lnk.adc_start, lnk.adc_input,
                                         s_ff.bus_ack, lnk.bus_req, lnk.irq};
          default:       nxt_s.prdata = 32'h0;
        endcase
      end
    end else if (access) begin
      nxt_s.pready = 1'b0;
      if (pwrite) begin
        case (paddr)
          DMC_A_CTRL: nxt_s.grant_en = pwdata[0];
          DMC_A_REGCMD: begin
            nxt_s.reg_addr = pwdata[11:0];
            nxt_s.reg_wdata = pwdata[19:12];
            nxt_s.reg_wr = pwdata[20];
            nxt_s.reg_rd = !pwdata[20];
            nxt_s.rstage = {1'b0, !pwdata[20]};
          end
          DMC_A_MEMCMD: begin
            nxt_s.maddr = pwdata[11:0];
            cpu_we = pwdata[20];
          end
          DMC_A_EVENT: begin
            // raw peripheral events, no interrupt gating
            nxt_s.trig = pwdata[9:0];
            nxt_s.adc_done = pwdata[10];
            nxt_s.adc_data = pwdata[25:16];
          end
          default: ;
        endcase
      end
    end else begin
      nxt_s.pready = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  // register file, engine write first
  always_ff @(posedge clock) begin
    if (lnk.mem_wr)
      mem[lnk.mem_addr[AW-1:0]] <= lnk.mem_wdata;
    else if (cpu_we)
      mem[pwdata[AW-1:0]] <= pwdata[19:12];
  end

  assign prdata        = s_ff.prdata;
  assign pready        = s_ff.pready;
  assign lnk.bus_ack   = s_ff.bus_ack;
  assign lnk.reg_wr    = s_ff.reg_wr;
  assign lnk.reg_rd    = s_ff.reg_rd;
  assign lnk.reg_addr  = s_ff.reg_addr;
  assign lnk.reg_wdata = s_ff.reg_wdata;
  assign lnk.mem_rdata = s_ff.mem_rdata;
  assign lnk.trig      = s_ff.trig;
  assign lnk.adc_done  = s_ff.adc_done;
  assign lnk.adc_data  = s_ff.adc_data;
endmodule : dmc_host

// *** verilog/dmc_if.sv ***
`timescale 1ns/1ps
// Purpose: link between transfer engine and cpu/peripheral side
// Assumes: one clock, all signals synchronous
// Notes:   reg_* and mem_* answers come one cycle after the strobe
interface dmc_if;
  // register access into the engine
  logic        reg_wr;
  logic        reg_rd;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  // system bus borrowing
  logic        bus_req;
  logic        bus_ack;
  logic [11:0] mem_addr;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  // peripheral triggers and converter
  logic [9:0]  trig;
  logic        adc_done;
  logic [9:0]  adc_data;
  logic        adc_start;
  logic [3:0]  adc_input;
  logic [2:0]  irq;

  modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata, bus_ack, mem_rdata, trig,
               adc_done, adc_data,
               output reg_rdata, bus_req, mem_addr, mem_rd, mem_wr, mem_wdata,
               adc_start, adc_input, irq);
  modport host (output reg_wr, reg_rd, reg_addr, reg_wdata, bus_ack, mem_rdata, trig,
                adc_done, adc_data,
                input reg_rdata, bus_req, mem_addr, mem_rd, mem_wr, mem_wdata,
                adc_start, adc_input, irq);
endinterface : dmc_if

// *** verilog/dmc_pkg.sv ***
// Purpose: shared constants and types of the three-channel transfer engine
// Assumes: 12-bit register file space, 8-bit data
// Notes:   Operation
package dmc_pkg;
  // device register map (12-bit register file addresses)
  localparam logic [11:0] DMC_CTL0   = 12'hFB0;
  localparam logic [11:0] DMC_IO0    = 12'hFB1;
  localparam logic [11:0] DMC_HN0    = 12'hFB2;
  localparam logic [11:0] DMC_START0 = 12'hFB3;
  localparam logic [11:0] DMC_END0   = 12'hFB4;
  localparam logic [11:0] DMC_CTL1   = 12'hFB8;
  localparam logic [11:0] DMC_IO1    = 12'hFB9;
  localparam logic [11:0] DMC_HN1    = 12'hFBA;
  localparam logic [11:0] DMC_START1 = 12'hFBB;
  localparam logic [11:0] DMC_END1   = 12'hFBC;
  localparam logic [11:0] DMC_ABASE  = 12'hFBD;
  localparam logic [11:0] DMC_ACTL   = 12'hFBE;
  localparam logic [11:0] DMC_ASTAT  = 12'hFBF;
  localparam logic [3:0]  DMC_PERIPH_NIB = 4'hF;
  localparam logic [7:0]  DMC_CTL_RST = 8'h00;
  // channel control fields
  localparam int DMC_B_EN   = 7;
  localparam int DMC_B_LOOP = 6;
  localparam int DMC_B_DIR  = 5;
  localparam int DMC_B_IE   = 4;
  localparam int DMC_B_WORD_SELECT_BIT = 3;
  // converter control: enable 7, irq 6, reserved 5:4, count 3:0
  localparam logic [7:0] DMC_ACTL_MASK = 8'hCF;
  // trigger select codes
  localparam logic [2:0] DMC_TS_UART0 = 3'h4;
  localparam logic [2:0] DMC_TS_UART1 = 3'h5;
  localparam logic [2:0] DMC_TS_TWI   = 3'h6;
  // trigger vector: 3:0 timers, 5:4 rx ready, 7:6 tx empty, 8 twi rx, 9 twi tx
  localparam int DMC_TRIG_W = 10;
  // host APB map (byte addresses)
  localparam logic [7:0] DMC_A_CTRL    = 8'h00;
  localparam logic [7:0] DMC_A_REGCMD  = 8'h04;
  localparam logic [7:0] DMC_A_REGSTAT = 8'h08;
  localparam logic [7:0] DMC_A_MEMCMD  = 8'h0C;
  localparam logic [7:0] DMC_A_MEMDATA = 8'h10;
  localparam logic [7:0] DMC_A_EVENT   = 8'h14;
  localparam logic [7:0] DMC_A_STATUS  = 8'h18;

  typedef enum logic [2:0] {
    DMC_S_IDLE  = 3'b000,
    DMC_S_REQ   = 3'b001,
    DMC_S_RWAIT = 3'b010,
    DMC_S_RCAP  = 3'b011,
    DMC_S_WDONE = 3'b100,
    DMC_S_REL   = 3'b101
  } dmc_state_t;
endpackage : dmc_pkg
